// ---- include/dsrc_pkg.sv ----
package dsrc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, printed offsets
  localparam logic [11:0] ADDR_ENABLE = 12'hee0;
  localparam logic [11:0] ADDR_STATUS = 12'hee1;
  localparam logic [11:0] ADDR_SYS_RATE = 12'hee2;
  localparam logic [11:0] ADDR_SEC_RATE = 12'hee3;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'hee4;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'hee5;
  localparam logic [11:0] ADDR_LOCK = 12'hee6;
  localparam logic [11:0] ADDR_PIN_SEL = 12'hee7;
  localparam logic [11:0] ADDR_SRC_FIRST = 12'ha80;
  localparam logic [11:0] ADDR_SRC_LAST = 12'ha98;
  localparam int SRC_COUNT = 25;

  ////////////////////////////////////////////////////////////////////////////
  // fields
  localparam int PATH_COUNT = 4;
  localparam int BIT_P1_RIGHT = 0;
  localparam int BIT_P1_LEFT = 1;
  localparam int BIT_P2_RIGHT = 2;
  localparam int BIT_P2_LEFT = 3;
  localparam int RATE_LSB = 11;
  localparam int RATE_MSB = 14;
  localparam int IRQ_UNDERCLOCK_BIT = 4;
  localparam int IRQ_WIDTH = 5;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and codes
  localparam logic [3:0] SYS_RATE_RESET = 4'h0;
  localparam logic [3:0] SEC_RATE_RESET = 4'h8;
  localparam logic [3:0] SYS_SLOT_ONE = 4'h0;
  localparam logic [3:0] SYS_SLOT_TWO = 4'h1;
  localparam logic [3:0] SYS_SLOT_THREE = 4'h2;
  localparam logic [3:0] SEC_SLOT_ONE = 4'h8;
  localparam logic [3:0] SEC_SLOT_TWO = 4'h9;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [2:0] PIN_SEL_UNDERCLOCK = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // timing and load
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int LOCK_TIME_US = 1000;
  localparam int LOCK_CYCLES = LOCK_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam logic [15:0] PATH_CYCLE_COST = 16'h0040;
  localparam int LOCK_CNT_W = 20;

  typedef enum logic [1:0] {
    LK_IDLE,
    LK_SETTLE,
    LK_LOCKED
  } dsrc_lock_state_t;

endpackage

// ---- logic/dsrc_lock_tracker.sv ----
`timescale 1ns/1ps
module dsrc_lock_tracker #(
  parameter int LOCK_CYCLES = dsrc_pkg::LOCK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // path control
  input wire logic run,
  input wire logic cfgValid,
  input wire logic restart,
  // lock result
  output logic locked
);

  localparam logic [dsrc_pkg::LOCK_CNT_W-1:0] LAST = dsrc_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1);

  dsrc_pkg::dsrc_lock_state_t state_reg;
  dsrc_pkg::dsrc_lock_state_t state_next;
  logic [dsrc_pkg::LOCK_CNT_W-1:0] count_reg;
  logic [dsrc_pkg::LOCK_CNT_W-1:0] count_next;

  ////////////////////////////////////////////////////////////////////////////
  // reserved rate codes never lock, so a bad setup cannot look healthy
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      dsrc_pkg::LK_IDLE: begin
        count_next = '0;
        if (run && cfgValid) begin
          state_next = dsrc_pkg::LK_SETTLE;
        end
      end
      dsrc_pkg::LK_SETTLE: begin
        count_next = count_reg + 1'b1;
        if (count_reg == LAST) begin
          state_next = dsrc_pkg::LK_LOCKED;
        end
      end
      dsrc_pkg::LK_LOCKED: begin
        count_next = '0;
      end
      default: begin
        state_next = dsrc_pkg::LK_IDLE;
        count_next = '0;
      end
    endcase
    if (!run || !cfgValid || restart) begin
      state_next = dsrc_pkg::LK_IDLE;
      count_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= dsrc_pkg::LK_IDLE;
      count_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign locked = (state_reg == dsrc_pkg::LK_LOCKED);

endmodule

// ---- logic/dsrc_rate_converter_ctrl.sv ----
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module dsrc_rate_converter_ctrl #(
  parameter int LOCK_CYCLES = dsrc_pkg::LOCK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // clock load reporting, cycles per sample
  input wire logic [15:0] sysCyclesAvail,
  input wire logic [15:0] secCyclesAvail,
  input wire logic [15:0] sysMixerLoad,
  input wire logic [15:0] secMixerLoad,
  // clock configuration change pulses
  input wire logic sysClkChange,
  input wire logic secClkChange,
  // datapath control
  output logic [3:0] pathRun,
  output logic [2:0] systemSideRateSelect,
  output logic [1:0] secondarySideRateSelect,
  output logic [dsrc_pkg::SRC_COUNT*16-1:0] converterInputSelect,
  // status outputs
  output logic [3:0] pathLock,
  output logic lockPin,
  output logic underclockPin,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] enable_reg;
  logic [3:0] run_reg;
  logic [3:0] run_next;
  logic [3:0] sysRate_reg;
  logic [3:0] secRate_reg;
  logic [dsrc_pkg::IRQ_WIDTH-1:0] irqStatus_reg;
  logic [dsrc_pkg::IRQ_WIDTH-1:0] irqStatus_next;
  logic [dsrc_pkg::IRQ_WIDTH-1:0] irqMask_reg;
  logic [2:0] pinSel_reg;
  logic [3:0] lockPrev_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [2:0] sysSel_reg;
  logic [1:0] secSel_reg;
  logic lockPin_reg;
  logic [15:0] srcSel_reg [dsrc_pkg::SRC_COUNT];

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire hitEnable = (regAddr == dsrc_pkg::ADDR_ENABLE);
  wire hitStatus = (regAddr == dsrc_pkg::ADDR_STATUS);
  wire hitSysRate = (regAddr == dsrc_pkg::ADDR_SYS_RATE);
  wire hitSecRate = (regAddr == dsrc_pkg::ADDR_SEC_RATE);
  wire hitIrqStatus = (regAddr == dsrc_pkg::ADDR_IRQ_STATUS);
  wire hitIrqMask = (regAddr == dsrc_pkg::ADDR_IRQ_MASK);
  wire hitLock = (regAddr == dsrc_pkg::ADDR_LOCK);
  wire hitPinSel = (regAddr == dsrc_pkg::ADDR_PIN_SEL);
  wire hitSrc = (regAddr >= dsrc_pkg::ADDR_SRC_FIRST) && (regAddr <= dsrc_pkg::ADDR_SRC_LAST);
  wire [11:0] srcOffset = regAddr - dsrc_pkg::ADDR_SRC_FIRST;
  wire [4:0] srcIndex = srcOffset[4:0];

  wire wrEnable = regWrite && hitEnable;
  wire wrSysRate = regWrite && hitSysRate;
  wire wrSecRate = regWrite && hitSecRate;
  wire wrIrqStatus = regWrite && hitIrqStatus;
  wire wrIrqMask = regWrite && hitIrqMask;
  wire wrPinSel = regWrite && hitPinSel;
  wire wrSrc = regWrite && hitSrc;

  wire [3:0] wrRateField = regWdata[dsrc_pkg::RATE_MSB:dsrc_pkg::RATE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // rate decode; reserved codes select no slot
  wire sysSlotOne = (sysRate_reg == dsrc_pkg::SYS_SLOT_ONE);
  wire sysSlotTwo = (sysRate_reg == dsrc_pkg::SYS_SLOT_TWO);
  wire sysSlotThree = (sysRate_reg == dsrc_pkg::SYS_SLOT_THREE);
  wire secSlotOne = (secRate_reg == dsrc_pkg::SEC_SLOT_ONE);
  wire secSlotTwo = (secRate_reg == dsrc_pkg::SEC_SLOT_TWO);
  wire sysRateValid = sysSlotOne || sysSlotTwo || sysSlotThree;
  wire secRateValid = secSlotOne || secSlotTwo;
  wire rateValid = sysRateValid && secRateValid;

  // any retune of either side forces every path to resettle
  wire lockRestart = wrSysRate || wrSecRate || sysClkChange || secClkChange;

  ////////////////////////////////////////////////////////////////////////////
  // enable admission against the cycle budget
  logic [16:0] sysLoad;
  logic [16:0] secLoad;
  logic [16:0] sysTry;
  logic [16:0] secTry;
  logic underclockEvent;

  always_comb begin
    run_next = run_reg;
    sysLoad = {1'b0, sysMixerLoad};
    secLoad = {1'b0, secMixerLoad};
    sysTry = 17'h0_0000;
    secTry = 17'h0_0000;
    underclockEvent = 1'b0;
    if (wrEnable) begin
      for (int i = 0; i < dsrc_pkg::PATH_COUNT; i++) begin
        run_next[i] = run_reg[i] & regWdata[i];
        if (run_next[i]) begin
          sysLoad = sysLoad + {1'b0, dsrc_pkg::PATH_CYCLE_COST};
          secLoad = secLoad + {1'b0, dsrc_pkg::PATH_CYCLE_COST};
        end
      end
      // newly asked paths are taken in bit order until the budget runs out
      for (int i = 0; i < dsrc_pkg::PATH_COUNT; i++) begin
        sysTry = sysLoad + {1'b0, dsrc_pkg::PATH_CYCLE_COST};
        secTry = secLoad + {1'b0, dsrc_pkg::PATH_CYCLE_COST};
        if (regWdata[i] && !run_reg[i]) begin
          if ((sysTry <= {1'b0, sysCyclesAvail}) && (secTry <= {1'b0, secCyclesAvail})) begin
            run_next[i] = 1'b1;
            sysLoad = sysTry;
            secLoad = secTry;
          end else begin
            underclockEvent = 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock tracking, one tracker per path
  logic [3:0] lockNow;

  genvar g;
  generate
    for (g = 0; g < dsrc_pkg::PATH_COUNT; g++) begin : gLock
      dsrc_lock_tracker #(
        .LOCK_CYCLES(LOCK_CYCLES)
      ) uLock (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .run(run_reg[g]),
        .cfgValid(rateValid),
        .restart(lockRestart),
        .locked(lockNow[g])
      );
    end
  endgenerate

  wire [3:0] lockRise = lockNow & ~lockPrev_reg;
  wire [dsrc_pkg::IRQ_WIDTH-1:0] irqSet = {underclockEvent, lockRise};
  wire [dsrc_pkg::IRQ_WIDTH-1:0] irqClr = wrIrqStatus ? regWdata[dsrc_pkg::IRQ_WIDTH-1:0] : '0;

  // set beats clear so an event landing on the clear write survives
  assign irqStatus_next = (irqStatus_reg & ~irqClr) | irqSet;

  ////////////////////////////////////////////////////////////////////////////
  // output pin mux
  wire pinSelLock = (pinSel_reg < 3'(dsrc_pkg::PATH_COUNT));
  wire [1:0] pinLockIndex = pinSel_reg[1:0];
  wire lockPinNext = pinSelLock ? lockNow[pinLockIndex] :
                     (pinSel_reg == dsrc_pkg::PIN_SEL_UNDERCLOCK) ? irqStatus_reg[dsrc_pkg::IRQ_UNDERCLOCK_BIT] :
                     1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  wire [15:0] rdEnable = {12'h000, enable_reg};
  wire [15:0] rdStatus = {12'h000, run_reg};
  wire [15:0] rdSysRate = {1'b0, sysRate_reg, 11'h000};
  wire [15:0] rdSecRate = {1'b0, secRate_reg, 11'h000};
  wire [15:0] rdIrqStatus = {11'h000, irqStatus_reg};
  wire [15:0] rdIrqMask = {11'h000, irqMask_reg};
  wire [15:0] rdLock = {12'h000, lockNow};
  wire [15:0] rdPinSel = {13'h0000, pinSel_reg};
  wire [15:0] rdSrc = srcSel_reg[srcIndex];

  assign rdata_next = hitEnable ? rdEnable :
                      hitStatus ? rdStatus :
                      hitSysRate ? rdSysRate :
                      hitSecRate ? rdSecRate :
                      hitIrqStatus ? rdIrqStatus :
                      hitIrqMask ? rdIrqMask :
                      hitLock ? rdLock :
                      hitPinSel ? rdPinSel :
                      hitSrc ? rdSrc :
                      16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      enable_reg <= 4'h0;
      run_reg <= 4'h0;
    end else if (ce) begin
      if (wrEnable) begin
        enable_reg <= regWdata[3:0];
      end
      run_reg <= run_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sysRate_reg <= dsrc_pkg::SYS_RATE_RESET;
      secRate_reg <= dsrc_pkg::SEC_RATE_RESET;
    end else if (ce) begin
      if (wrSysRate) begin
        sysRate_reg <= wrRateField;
      end
      if (wrSecRate) begin
        secRate_reg <= wrRateField;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqStatus_reg <= '0;
      irqMask_reg <= '0;
      pinSel_reg <= 3'h0;
      lockPrev_reg <= 4'h0;
    end else if (ce) begin
      irqStatus_reg <= irqStatus_next;
      lockPrev_reg <= lockNow;
      if (wrIrqMask) begin
        irqMask_reg <= regWdata[dsrc_pkg::IRQ_WIDTH-1:0];
      end
      if (wrPinSel) begin
        pinSel_reg <= regWdata[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_reg <= 16'h0000;
    end else if (ce) begin
      rdata_reg <= regRead ? rdata_next : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered datapath selects; no slot while code is reserved
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sysSel_reg <= 3'h0;
      secSel_reg <= 2'h0;
      lockPin_reg <= 1'b0;
    end else if (ce) begin
      sysSel_reg <= {sysSlotThree, sysSlotTwo, sysSlotOne};
      secSel_reg <= {secSlotTwo, secSlotOne};
      lockPin_reg <= lockPinNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source select storage
  generate
    for (g = 0; g < dsrc_pkg::SRC_COUNT; g++) begin : gSrc
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          srcSel_reg[g] <= dsrc_pkg::REG_RESET;
        end else if (ce && wrSrc && (srcIndex == 5'(g))) begin
          srcSel_reg[g] <= regWdata;
        end
      end
      assign converterInputSelect[g*16 +: 16] = srcSel_reg[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // pair one runs sys to secondary, pair two back; datapath keeps each in one domain
  assign pathRun = run_reg;
  assign systemSideRateSelect = sysSel_reg;
  assign secondarySideRateSelect = secSel_reg;
  assign pathLock = lockNow;
  assign lockPin = lockPin_reg;
  assign underclockPin = irqStatus_reg[dsrc_pkg::IRQ_UNDERCLOCK_BIT];
  assign irq = |(irqStatus_reg & irqMask_reg);
  assign regRdata = rdata_reg;

endmodule

// ---- sim/dsrc_ctrl_props.sv ----
`timescale 1ns/1ps
module dsrc_ctrl_props #(
  parameter int LOCK_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  // watched outputs
  input wire logic [3:0] pathRun,
  input wire logic [2:0] systemSideRateSelect,
  input wire logic [1:0] secondarySideRateSelect,
  input wire logic [dsrc_pkg::SRC_COUNT*16-1:0] converterInputSelect,
  input wire logic [3:0] pathLock,
  input wire logic underclockPin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] runCnt;
  wire enWr = regWrite && regAddr == dsrc_pkg::ADDR_ENABLE;
  wire sysWr = regWrite && regAddr == dsrc_pkg::ADDR_SYS_RATE;
  wire secWr = regWrite && regAddr == dsrc_pkg::ADDR_SEC_RATE;
  ////////////////////////////////////////////////////////////////////////////
  // settle age of path 0, saturating so long runs stay legal
  always_ff @(posedge clk) begin
    if (!rst_b || !pathRun[0]) begin
      runCnt <= 8'h00;
    end else if (runCnt != 8'hff) begin
      runCnt <= runCnt + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  status_read_a: assert property ($past(regRead && regAddr == dsrc_pkg::ADDR_STATUS) |->
    regRdata == {12'h000, $past(pathRun)}) else $error("status readback wrong");
  run_keep_a: assert property ($past(enWr) |-> (pathRun & ~$past(regWdata[3:0])) == 4'h0
    && (pathRun & $past(pathRun)) == ($past(pathRun) & $past(regWdata[3:0]))) else $error("running path disturbed");
  run_hold_a: assert property (!$past(enWr) |-> $stable(pathRun)) else $error("path changed without write");
  uc_set_a: assert property ($rose(underclockPin) |-> $past(enWr)
    && ($past(regWdata[3:0]) & ~pathRun) != 4'h0) else $error("underclock without refusal");
  uc_sticky_a: assert property ($fell(underclockPin) |->
    $past(regWrite && regAddr == dsrc_pkg::ADDR_IRQ_STATUS && regWdata[4])) else $error("underclock lost");
  lock_settle_a: assert property ($rose(pathLock[0]) |-> runCnt >= LOCK_CYCLES + 1)
    else $error("lock came too early");
  lock_drop_a: assert property ((pathLock & ~pathRun & ~$past(pathRun)) == 4'h0)
    else $error("lock on idle path");
  rate_unlock_a: assert property ($past(sysWr || secWr, 2) |-> pathLock == 4'h0)
    else $error("lock kept over rate change");
  sys_rate_a: assert property ($past(sysWr, 2) |-> systemSideRateSelect ==
    ($past(regWdata[14:11], 2) < 4'h3 ? 3'h1 << $past(regWdata[12:11], 2) : 3'h0)) else $error("system slot wrong");
  sec_rate_a: assert property ($past(secWr, 2) |-> secondarySideRateSelect ==
    ($past(regWdata[14:11], 2) == 4'h8 ? 2'h1 : $past(regWdata[14:11], 2) == 4'h9 ? 2'h2 : 2'h0))
    else $error("secondary slot wrong");
  src_sel_a: assert property ($past(regWrite && regAddr == dsrc_pkg::ADDR_SRC_LAST) |->
    converterInputSelect[24*16+:16] == $past(regWdata)) else $error("source select not stored");
endmodule

// ---- sim/dsrc_mix_model.sv ----
`timescale 1ns/1ps
module dsrc_mix_model (
  // clock
  input wire logic clk,
  // bench knobs
  input wire logic [15:0] budget,
  input wire logic [15:0] load,
  input wire logic bumpSys,
  input wire logic bumpSec,
  // toward the controller
  output logic [15:0] sysCyclesAvail,
  output logic [15:0] secCyclesAvail,
  output logic [15:0] sysMixerLoad,
  output logic [15:0] secMixerLoad,
  output logic sysClkChange,
  output logic secClkChange
);
  // figures come from the clock tree a cycle late, like a measurement
  always_ff @(posedge clk) begin
    sysCyclesAvail <= budget;
    secCyclesAvail <= budget;
    sysMixerLoad <= load;
    secMixerLoad <= load;
    sysClkChange <= bumpSys;
    secClkChange <= bumpSec;
  end
endmodule

// ---- sim/dsrc_rate_converter_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module dsrc_rate_converter_ctrl_tb_top;
  localparam int LOCK = 8;
  logic clk;
  logic rst_b;
  logic ce;
  logic [11:0] regAddr;
  logic [15:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [15:0] budget;
  logic [15:0] load;
  logic bumpSys;
  logic bumpSec;
  logic [15:0] regRdata;
  logic [15:0] sysAvail;
  logic [15:0] secAvail;
  logic [15:0] sysLoad;
  logic [15:0] secLoad;
  logic sysChg;
  logic secChg;
  logic [3:0] pathRun;
  logic [2:0] sysSel;
  logic [1:0] secSel;
  logic [dsrc_pkg::SRC_COUNT*16-1:0] srcSel;
  logic [3:0] pathLock;
  logic lockPin;
  logic underclockPin;
  logic irq;
  int mismatches = 0;
  int testsRun = 0;
  ////////////////////////////////////////////////////////////////////////////
  dsrc_mix_model i_dsrc_mix_model (.clk(clk), .budget(budget), .load(load), .bumpSys(bumpSys),
    .bumpSec(bumpSec), .sysCyclesAvail(sysAvail), .secCyclesAvail(secAvail), .sysMixerLoad(sysLoad),
    .secMixerLoad(secLoad), .sysClkChange(sysChg), .secClkChange(secChg));
  // clock enable driven so the freeze path is exercised once
  dsrc_rate_converter_ctrl #(.LOCK_CYCLES(LOCK)) i_dsrc_rate_converter_ctrl (.clk(clk), .rst_b(rst_b),
    .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .sysCyclesAvail(sysAvail), .secCyclesAvail(secAvail), .sysMixerLoad(sysLoad),
    .secMixerLoad(secLoad), .sysClkChange(sysChg), .secClkChange(secChg), .pathRun(pathRun),
    .systemSideRateSelect(sysSel), .secondarySideRateSelect(secSel), .converterInputSelect(srcSel),
    .pathLock(pathLock), .lockPin(lockPin), .underclockPin(underclockPin), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, exp, "read");
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    // tests need well under a thousand cycles; ten thousand is ample
    #200_000;
    mismatches++;
    printVerdict;
  end
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    regAddr = 12'h000;
    regWdata = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    budget = 16'h0080;
    load = 16'h0000;
    bumpSys = 1'b0;
    bumpSec = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rchk(dsrc_pkg::ADDR_ENABLE, 16'h0000);
    rchk(dsrc_pkg::ADDR_STATUS, 16'h0000);
    rchk(dsrc_pkg::ADDR_SYS_RATE, 16'h0000);
    rchk(dsrc_pkg::ADDR_SEC_RATE, 16'h4000);
    chk({13'h0000, sysSel}, 16'h0001, "sys slot");
    chk({14'h0000, secSel}, 16'h0001, "sec slot");
    rchk(12'h0123, 16'h0000);
    $display("test reset done");
    // room for two paths: right and left of pair one only
    wr(dsrc_pkg::ADDR_ENABLE, 16'h000f);
    chk({12'h000, pathRun}, 16'h0003, "admitted");
    chk({15'h0000, underclockPin}, 16'h0001, "underclock");
    rchk(dsrc_pkg::ADDR_STATUS, 16'h0003);
    wr(dsrc_pkg::ADDR_STATUS, 16'h000f);
    rchk(dsrc_pkg::ADDR_STATUS, 16'h0003);
    wr(dsrc_pkg::ADDR_IRQ_MASK, 16'h0010);
    tick(1);
    chk({15'h0000, irq}, 16'h0001, "irq");
    wr(dsrc_pkg::ADDR_IRQ_STATUS, 16'h0010);
    tick(1);
    chk({14'h0000, underclockPin, irq}, 16'h0000, "irq clear");
    $display("test refusal done");
    // mixing load grows: a new refusal must spare the running pair
    @(posedge clk);
    load <= 16'h0040;
    wr(dsrc_pkg::ADDR_ENABLE, 16'h000f);
    chk({11'h000, underclockPin, pathRun}, 16'h0013, "spared");
    wr(dsrc_pkg::ADDR_IRQ_STATUS, 16'h0010);
    @(posedge clk);
    budget <= 16'h0200;
    wr(dsrc_pkg::ADDR_ENABLE, 16'h0008);
    chk({11'h000, underclockPin, pathRun}, 16'h0008, "pair two left");
    wr(dsrc_pkg::ADDR_ENABLE, 16'h000f);
    chk({11'h000, underclockPin, pathRun}, 16'h000f, "all on");
    tick(LOCK + 3);
    rchk(dsrc_pkg::ADDR_LOCK, 16'h000f);
    rchk(dsrc_pkg::ADDR_IRQ_STATUS, 16'h000f);
    wr(dsrc_pkg::ADDR_PIN_SEL, 16'h0000);
    tick(2);
    chk({15'h0000, lockPin}, 16'h0001, "lock pin");
    wr(dsrc_pkg::ADDR_PIN_SEL, 16'h0004);
    tick(2);
    chk({15'h0000, lockPin}, 16'h0000, "uc pin");
    wr(dsrc_pkg::ADDR_SYS_RATE, 16'h0800);
    tick(1);
    chk({9'h000, sysSel, pathLock}, 16'h0020, "relock sys");
    tick(LOCK + 3);
    chk({12'h000, pathLock}, 16'h000f, "locked");
    @(posedge clk);
    bumpSec <= 1'b1;
    @(posedge clk);
    bumpSec <= 1'b0;
    tick(2);
    chk({12'h000, pathLock}, 16'h0000, "clock change");
    wr(dsrc_pkg::ADDR_SEC_RATE, 16'h4800);
    tick(1);
    chk({10'h000, secSel, pathLock}, 16'h0020, "relock sec");
    wr(dsrc_pkg::ADDR_ENABLE, 16'h0000);
    chk({12'h000, pathRun}, 16'h0000, "all off");
    $display("test lock done");
    // reserved codes only with every path off
    for (int c = 0; c < 4; c++) begin
      wr(dsrc_pkg::ADDR_SYS_RATE, 16'(c) << 11);
      tick(1);
      chk({13'h0000, sysSel}, (c < 3) ? 16'h0001 << c : 16'h0000, "sys code");
    end
    for (int c = 8; c < 11; c++) begin
      wr(dsrc_pkg::ADDR_SEC_RATE, 16'(c) << 11);
      tick(1);
      chk({14'h0000, secSel}, (c < 10) ? 16'h0001 << (c - 8) : 16'h0000, "sec code");
    end
    wr(dsrc_pkg::ADDR_SRC_FIRST, 16'h1234);
    chk(srcSel[15:0], 16'h1234, "src first");
    wr(dsrc_pkg::ADDR_SRC_LAST, 16'h5a5a);
    rchk(dsrc_pkg::ADDR_SRC_LAST, 16'h5a5a);
    rchk(12'ha99, 16'h0000);
    $display("test rates and sources done");
    // clock enable low: a write must leave every register untouched
    @(posedge clk);
    ce <= 1'b0;
    wr(dsrc_pkg::ADDR_ENABLE, 16'h0001);
    chk({12'h000, pathRun}, 16'h0000, "frozen run");
    @(posedge clk);
    ce <= 1'b1;
    rchk(dsrc_pkg::ADDR_ENABLE, 16'h0000);
    $display("test freeze done");
    printVerdict;
  end
endmodule
bind dsrc_rate_converter_ctrl dsrc_ctrl_props #(.LOCK_CYCLES(LOCK_CYCLES)) i_dsrc_ctrl_props (.clk(clk),
  .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .pathRun(pathRun), .systemSideRateSelect(systemSideRateSelect),
  .secondarySideRateSelect(secondarySideRateSelect), .converterInputSelect(converterInputSelect),
  .pathLock(pathLock), .underclockPin(underclockPin));
